// ---- rtl/cvs_vseq_gen.v ----
// Vertical sequence generator: two pattern groups, masking, alternation
`timescale 1ns/1ns
`include "cvs_defs.vh"
module cvs_vseq_gen (
  input  wire                    ref_clk,
  input  wire                    rst,
  input  wire                    seq_start,
  input  wire                    seq_run,
  input  wire [`CVS_PIX_W-1:0]   line_len,
  input  wire [1:0]              grp_a_alt_select,
  input  wire [`CVS_PIX_W-1:0]   grp_a_begin_pixel,
  input  wire [`CVS_PIX_W-1:0]   grp_b_begin_pixel,
  input  wire [`CVS_PIX_W-1:0]   grp_a_pattern_len,
  input  wire [`CVS_PIX_W-1:0]   grp_b_pattern_len,
  input  wire [`CVS_REP_W-1:0]   grp_b_repeats_odd,
  input  wire [`CVS_REP_W-1:0]   grp_b_repeats_even,
  input  wire [`CVS_REP_W-1:0]   grp_a_repeats_first,
  input  wire [`CVS_REP_W-1:0]   grp_a_repeats_second,
  input  wire [`CVS_REP_W-1:0]   grp_a_repeats_third,
  input  wire [`CVS_REP_W-1:0]   grp_a_repeats_fourth,
  input  wire [`CVS_PIX_W-1:0]   mask_begin_one,
  input  wire [`CVS_PIX_W-1:0]   mask_end_one,
  input  wire [`CVS_PIX_W-1:0]   mask_begin_two,
  input  wire [`CVS_PIX_W-1:0]   mask_end_two,
  input  wire [1:0]              output_mask_mode,
  input  wire                    hold_on,
  input  wire [`CVS_LINE_W-1:0]  special_insert_line,
  input  wire                    special_insert_on,
  input  wire [`CVS_NOUT-1:0]    output_group_map,
  input  wire                    combine_groups,
  input  wire [`CVS_SEL_W-1:0]   grp_a_pattern_select,
  input  wire [`CVS_SEL_W-1:0]   grp_b_pattern_select,
  input  wire [`CVS_NOUT-1:0]    start_polarity,
  input  wire [`CVS_NOUT-1:0]    pat_a_toggle,
  input  wire [`CVS_NOUT-1:0]    pat_b_toggle,
  input  wire                    blank_alternation_on,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_1,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_2,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_3,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_4,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_5,
  input  wire [`CVS_PIX_W-1:0]   blank_edge_pos_6,
  output wire [`CVS_NOUT-1:0]    vertical_out,
  output wire                    horizontal_blanking,
  output wire [`CVS_SEL_W-1:0]   pat_a_sel,
  output wire [`CVS_PIX_W-1:0]   pat_a_pos,
  output wire                    pat_a_act,
  output wire [`CVS_SEL_W-1:0]   pat_b_sel,
  output wire [`CVS_PIX_W-1:0]   pat_b_pos,
  output wire                    pat_b_act,
  output wire                    line_odd,
  output wire [`CVS_LINE_W-1:0]  line_num,
  output wire [`CVS_PIX_W-1:0]   pixel_num
);

  reg  [1:0]              state_r;
  reg  [1:0]              state_nxt;
  reg  [`CVS_PIX_W-1:0]   pix_r;
  reg  [`CVS_LINE_W-1:0]  line_r;
  reg  [1:0]              phase_r;
  reg                     odd_r;
  reg                     a_act_r;
  reg  [`CVS_PIX_W-1:0]   a_pos_r;
  reg  [`CVS_REP_W-1:0]   a_rep_r;
  reg                     a_act_nxt;
  reg  [`CVS_PIX_W-1:0]   a_pos_nxt;
  reg  [`CVS_REP_W-1:0]   a_rep_nxt;
  reg                     b_act_r;
  reg  [`CVS_PIX_W-1:0]   b_pos_r;
  reg  [`CVS_REP_W-1:0]   b_rep_r;
  reg                     b_act_nxt;
  reg  [`CVS_PIX_W-1:0]   b_pos_nxt;
  reg  [`CVS_REP_W-1:0]   b_rep_nxt;
  reg                     pb_act_r;
  reg  [`CVS_PIX_W-1:0]   pb_pos_r;
  reg  [`CVS_SEL_W-1:0]   pa_sel_r;
  reg  [`CVS_SEL_W-1:0]   pb_sel_r;
  reg  [`CVS_NOUT-1:0]    xv_r;
  reg  [`CVS_NOUT-1:0]    xv_nxt;
  reg                     blk_r;
  reg  [`CVS_REP_W-1:0]   a_lim;
  wire                    running;
  wire                    line_end;
  wire                    restart;
  wire                    win_one;
  wire                    win_two;
  wire                    mask_now;
  wire                    a_frz;
  wire                    a_start;
  wire                    a_wrap;
  wire                    a_last;
  wire [`CVS_REP_W-1:0]   b_lim;
  wire                    b_start;
  wire                    b_wrap;
  wire                    b_last;
  wire                    ins_line;
  wire [`CVS_NOUT-1:0]    tog;
  wire [`CVS_NBLK*`CVS_PIX_W-1:0] blk_pos;
  wire [`CVS_NBLK-1:0]    blk_hit;
  wire [`CVS_NBLK-1:0]    blk_use;

  assign running = (state_r == `CVS_ST_RUN);
  assign line_end = running &&
                    (({1'b0, pix_r} + `CVS_CNT_ONE) >= {1'b0, line_len});
  assign restart = seq_start | line_end | ~running;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CVS_ST_IDLE: begin
        if (seq_start && seq_run) begin
          state_nxt = `CVS_ST_RUN;
        end
      end
      `CVS_ST_RUN: begin
        if (!seq_run) begin
          state_nxt = `CVS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = `CVS_ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= `CVS_ST_IDLE;
      pix_r   <= `CVS_PIX_ZERO;
      line_r  <= `CVS_LINE_ZERO;
      phase_r <= `CVS_PH_ZERO;
      odd_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (seq_start || !running) begin
        pix_r   <= `CVS_PIX_ZERO;
        line_r  <= `CVS_LINE_ZERO;
        phase_r <= `CVS_PH_ZERO;
        odd_r   <= 1'b1;
      end else if (line_end) begin
        pix_r  <= `CVS_PIX_ZERO;
        line_r <= line_r + `CVS_LINE_ONE;
        odd_r  <= ~odd_r;
        if (phase_r >= grp_a_alt_select) begin
          phase_r <= `CVS_PH_ZERO;
        end else begin
          phase_r <= phase_r + `CVS_PH_ONE;
        end
      end else begin
        pix_r <= pix_r + `CVS_PIX_ONE;
      end
    end
  end

  assign win_one = output_mask_mode[`CVS_MSK_W1] &&
                   (pix_r >= mask_begin_one) && (pix_r < mask_end_one);
  assign win_two = output_mask_mode[`CVS_MSK_W2] &&
                   (pix_r >= mask_begin_two) && (pix_r < mask_end_two);
  assign mask_now = running && (win_one || win_two);

  // four stored counts, only count changes
  always @* begin
    case (phase_r)
      `CVS_PH_ZERO: a_lim = grp_a_repeats_first;
      `CVS_PH_ONE: a_lim = grp_a_repeats_second;
      `CVS_PH_TWO: a_lim = grp_a_repeats_third;
      `CVS_PH_THREE: a_lim = grp_a_repeats_fourth;
      default: a_lim = grp_a_repeats_first;
    endcase
  end

  assign a_frz = hold_on && mask_now;
  assign a_start = (pix_r == grp_a_begin_pixel) && (a_lim != `CVS_REP_ZERO);
  assign a_wrap = ({1'b0, a_pos_r} + `CVS_CNT_ONE) >= {1'b0, grp_a_pattern_len};
  assign a_last = ({1'b0, a_rep_r} + `CVS_RCNT_ONE) >= {1'b0, a_lim};

  always @* begin
    a_act_nxt = a_act_r;
    a_pos_nxt = a_pos_r;
    a_rep_nxt = a_rep_r;
    if (restart) begin
      a_act_nxt = 1'b0;
      a_pos_nxt = `CVS_PIX_ZERO;
      a_rep_nxt = `CVS_REP_ZERO;
    end else if (a_start && !a_act_r) begin
      a_act_nxt = 1'b1;
    end else if (a_act_r && !a_frz) begin
      if (a_wrap) begin
        a_pos_nxt = `CVS_PIX_ZERO;
        if (a_last) begin
          a_act_nxt = 1'b0;
        end else begin
          a_rep_nxt = a_rep_r + `CVS_REP_ONE;
        end
      end else begin
        a_pos_nxt = a_pos_r + `CVS_PIX_ONE;
      end
    end
  end

  // odd and even counts for group B
  assign b_lim = odd_r ? grp_b_repeats_odd : grp_b_repeats_even;
  assign b_start = (pix_r == grp_b_begin_pixel) && (b_lim != `CVS_REP_ZERO);
  assign b_wrap = ({1'b0, b_pos_r} + `CVS_CNT_ONE) >= {1'b0, grp_b_pattern_len};
  assign b_last = ({1'b0, b_rep_r} + `CVS_RCNT_ONE) >= {1'b0, b_lim};

  // Group B keeps counting through a hold window
  always @* begin
    b_act_nxt = b_act_r;
    b_pos_nxt = b_pos_r;
    b_rep_nxt = b_rep_r;
    if (restart) begin
      b_act_nxt = 1'b0;
      b_pos_nxt = `CVS_PIX_ZERO;
      b_rep_nxt = `CVS_REP_ZERO;
    end else if (b_start && !b_act_r) begin
      b_act_nxt = 1'b1;
    end else if (b_act_r) begin
      if (b_wrap) begin
        b_pos_nxt = `CVS_PIX_ZERO;
        if (b_last) begin
          b_act_nxt = 1'b0;
        end else begin
          b_rep_nxt = b_rep_r + `CVS_REP_ONE;
        end
      end else begin
        b_pos_nxt = b_pos_r + `CVS_PIX_ONE;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      a_act_r  <= 1'b0;
      a_pos_r  <= `CVS_PIX_ZERO;
      a_rep_r  <= `CVS_REP_ZERO;
      b_act_r  <= 1'b0;
      b_pos_r  <= `CVS_PIX_ZERO;
      b_rep_r  <= `CVS_REP_ZERO;
      pb_act_r <= 1'b0;
      pb_pos_r <= `CVS_PIX_ZERO;
      pa_sel_r <= `CVS_SEL_ZERO;
      pb_sel_r <= `CVS_SEL_ZERO;
    end else begin
      a_act_r  <= a_act_nxt;
      a_pos_r  <= a_pos_nxt;
      a_rep_r  <= a_rep_nxt;
      b_act_r  <= b_act_nxt;
      b_pos_r  <= b_pos_nxt;
      b_rep_r  <= b_rep_nxt;
      pa_sel_r <= grp_a_pattern_select;
      pb_sel_r <= grp_b_pattern_select;
      if (combine_groups) begin
        pb_act_r <= a_act_nxt;
        pb_pos_r <= a_pos_nxt;
      end else begin
        pb_act_r <= b_act_nxt;
        pb_pos_r <= b_pos_nxt;
      end
    end
  end

  assign ins_line = special_insert_on && (line_r == special_insert_line);

  genvar gi;
  generate
    for (gi = 0; gi < `CVS_NOUT; gi = gi + 1) begin : g_out
      wire ta;
      wire tb;
      assign ta = a_act_r && pat_a_toggle[gi];
      assign tb = pb_act_r && pat_b_toggle[gi];
      assign tog[gi] = combine_groups ? (ta | tb) :
                       ((output_group_map[gi] ? tb : ta) | (ins_line & tb));
    end
  endgenerate

  always @* begin
    xv_nxt = xv_r;
    if (restart) begin
      xv_nxt = start_polarity;
    end else if (mask_now) begin
      xv_nxt = xv_r;
    end else begin
      xv_nxt = xv_r ^ tog;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      xv_r <= `CVS_OUT_ZERO;
    end else begin
      xv_r <= xv_nxt;
    end
  end

  assign blk_pos = {blank_edge_pos_6, blank_edge_pos_5, blank_edge_pos_4,
                    blank_edge_pos_3, blank_edge_pos_2, blank_edge_pos_1};

  generate
    for (gi = 0; gi < `CVS_NBLK; gi = gi + 1) begin : g_blk
      assign blk_hit[gi] = (pix_r == blk_pos[gi*`CVS_PIX_W +: `CVS_PIX_W]);
    end
  endgenerate

  assign blk_use = !blank_alternation_on ? `CVS_BLK_ALL :
                   (odd_r ? `CVS_BLK_ODD : `CVS_BLK_EVEN);

  always @(posedge ref_clk) begin
    if (rst) begin
      blk_r <= 1'b0;
    end else if (restart) begin
      blk_r <= 1'b0;
    end else begin
      blk_r <= blk_r ^ (^(blk_hit & blk_use));
    end
  end

  assign vertical_out = xv_r;
  assign horizontal_blanking = blk_r;
  assign pat_a_sel = pa_sel_r;
  assign pat_a_pos = a_pos_r;
  assign pat_a_act = a_act_r;
  assign pat_b_sel = pb_sel_r;
  assign pat_b_pos = pb_pos_r;
  assign pat_b_act = pb_act_r;
  assign line_odd = odd_r;
  assign line_num = line_r;
  assign pixel_num = pix_r;

endmodule // cvs_vseq_gen

// ---- rtl/cvs_defs.vh ----
// Constants for the vertical sequence generator
`ifndef CVS_DEFS_VH
`define CVS_DEFS_VH
`define CVS_PIX_W 13
`define CVS_LINE_W 12
`define CVS_REP_W 12
`define CVS_NOUT 13
`define CVS_SEL_W 5
`define CVS_NBLK 6
`define CVS_PIX_ZERO 13'h0000
`define CVS_PIX_ONE 13'h0001
`define CVS_REP_ONE 12'h001
`define CVS_LINE_ZERO 12'h000
`define CVS_LINE_ONE 12'h001
`define CVS_REP_ZERO 12'h000
`define CVS_SEL_ZERO 5'h00
`define CVS_OUT_ZERO 13'h0000
`define CVS_CNT_ONE 14'h0001
`define CVS_RCNT_ONE 13'h0001
`define CVS_PH_ZERO 2'h0
`define CVS_PH_ONE 2'h1
`define CVS_PH_TWO 2'h2
`define CVS_PH_THREE 2'h3
`define CVS_MSK_W1 0
`define CVS_MSK_W2 1
`define CVS_BLK_ALL 6'h3F
`define CVS_BLK_ODD 6'h03
`define CVS_BLK_EVEN 6'h3C
`define CVS_ST_IDLE 2'h1
`define CVS_ST_RUN 2'h2
`endif

// ---- verif/cvs_pat_store.sv ----
// Behavioural pattern store that answers the generator's toggle lookups
`timescale 1ns/1ns
module cvs_pat_store (
  input  wire [4:0]  sel,
  input  wire [12:0] pos,
  output wire [12:0] toggle
);
  // Pattern n flips every output once, at position n of each repetition,
  // so an unmasked output fed by one group flips once per repetition actually run
  assign toggle = (pos == {8'h00, sel}) ? 13'h1FFF : 13'h0000;
endmodule // cvs_pat_store

// ---- verif/cvs_vseq_sva.sv ----
// Port-level property checker for the vertical sequence generator
`timescale 1ns/1ns
module cvs_vseq_sva (
  input wire        ref_clk,
  input wire        rst,
  input wire        seq_start,
  input wire        seq_run,
  input wire [12:0] line_len,
  input wire [4:0]  grp_a_pattern_select,
  input wire [12:0] mask_begin_one,
  input wire [12:0] mask_end_one,
  input wire [12:0] mask_begin_two,
  input wire [12:0] mask_end_two,
  input wire [1:0]  output_mask_mode,
  input wire        special_insert_on,
  input wire [12:0] output_group_map,
  input wire        combine_groups,
  input wire [12:0] start_polarity,
  input wire [12:0] pat_a_toggle,
  input wire [12:0] pat_b_toggle,
  input wire [12:0] vertical_out,
  input wire        horizontal_blanking,
  input wire [4:0]  pat_a_sel,
  input wire        pat_a_act,
  input wire        pat_b_act,
  input wire        line_odd,
  input wire [11:0] line_num,
  input wire [12:0] pixel_num
);
  // Restart and wrap edges reload the outputs, so they are left out here
  wire mid   = seq_run && !seq_start && (pixel_num + 13'h0001 < line_len);
  wire in_w1 = mid && output_mask_mode[0] && pixel_num >= mask_begin_one &&
               pixel_num < mask_end_one;
  wire in_w2 = mid && output_mask_mode[1] && pixel_num >= mask_begin_two &&
               pixel_num < mask_end_two;
  wire solo  = mid && !combine_groups && !special_insert_on;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  start_seq_a: assert property (seq_start && seq_run |=> pixel_num == 13'h0000 &&
    line_odd && line_num == 12'h000 && vertical_out == $past(start_polarity))
    else $error("sequence start state wrong");
  line_wrap_a: assert property (seq_run && !seq_start && line_len > 13'h0001 &&
    pixel_num == line_len - 13'h0001 |=> pixel_num == 13'h0000 && !horizontal_blanking &&
    line_num == $past(line_num) + 12'h001 && line_odd != $past(line_odd))
    else $error("line wrap wrong");
  mask_one_a: assert property (in_w1 |=> $stable(vertical_out))
    else $error("output moved in window one");
  mask_two_a: assert property (in_w2 |=> $stable(vertical_out))
    else $error("output moved in window two");
  grp_a_out_a: assert property (solo && output_mask_mode == 2'h0 && !output_group_map[0] &&
    pat_a_act && pat_a_toggle[0] |=> vertical_out[0] != $past(vertical_out[0]))
    else $error("group A toggle missed");
  grp_b_out_a: assert property (solo && output_mask_mode == 2'h0 && output_group_map[12] &&
    pat_b_act && pat_b_toggle[12] |=> vertical_out[12] != $past(vertical_out[12]))
    else $error("group B toggle missed");
  b_ignores_a_a: assert property (solo && output_group_map[12] && pat_a_act &&
    pat_a_toggle[12] && !(pat_b_act && pat_b_toggle[12]) |=> $stable(vertical_out[12]))
    else $error("group A toggle reached a group B output");
  sel_reg_a: assert property (1'b1 |=> pat_a_sel == $past(grp_a_pattern_select))
    else $error("pattern select not registered");
  cover property (special_insert_on && pat_b_act);
  cover property (combine_groups && pat_a_act);
  cover property (output_mask_mode == 2'h3 && in_w2);
endmodule // cvs_vseq_sva

// ---- verif/ccd_vertical_sequence_gen_tb_top.sv ----
// Self-checking bench for the vertical sequence generator
`timescale 1ns/1ns
module ccd_vertical_sequence_gen_tb_top;
  logic        ref_clk, rst, seq_start, seq_run, hold_on, special_insert_on, combine_groups;
  logic        blank_alternation_on, horizontal_blanking, pat_a_act, pat_b_act, line_odd;
  logic [1:0]  grp_a_alt_select, output_mask_mode;
  logic [4:0]  grp_a_pattern_select, grp_b_pattern_select, pat_a_sel, pat_b_sel;
  logic [11:0] grp_b_repeats_odd, grp_b_repeats_even, special_insert_line, line_num;
  logic [11:0] grp_a_repeats_first, grp_a_repeats_second, grp_a_repeats_third;
  logic [11:0] grp_a_repeats_fourth;
  logic [12:0] line_len, grp_a_begin_pixel, grp_b_begin_pixel, grp_a_pattern_len;
  logic [12:0] grp_b_pattern_len, mask_begin_one, mask_end_one, mask_begin_two, mask_end_two;
  logic [12:0] output_group_map, start_polarity, pat_a_toggle, pat_b_toggle, vertical_out;
  logic [12:0] pat_a_pos, pat_b_pos, pixel_num, blank_edge_pos_1, blank_edge_pos_2;
  logic [12:0] blank_edge_pos_3, blank_edge_pos_4, blank_edge_pos_5, blank_edge_pos_6;
  logic [7:0]  na, nb, nh;
  logic [12:0] fa, la, fb;
  int          bad_count = 0, n_checks = 0, cyc = 0;

  cvs_vseq_gen uut (.*);
  cvs_pat_store pat_a (.sel(pat_a_sel), .pos(pat_a_pos), .toggle(pat_a_toggle));
  cvs_pat_store pat_b (.sel(pat_b_sel), .pos(pat_b_pos), .toggle(pat_b_toggle));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling is about three times the cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic start;
    @(posedge ref_clk);
    #1 seq_start = 1'b1;
    @(posedge ref_clk);
    #1 seq_start = 1'b0;
    check(pixel_num, 16'h0000);
  endtask

  // Counts flips over one 40-pixel line; line-start reloads are not counted
  task automatic run_line;
    logic [12:0] pv;
    logic        ph;
    {na, nb, nh} = 24'h000000;
    {fa, la, fb} = 39'h0;
    pv = vertical_out;
    ph = horizontal_blanking;
    repeat (39) begin
      @(posedge ref_clk);
      #1;
      // First and last flip pixels show start position and pitch
      if (vertical_out[0] != pv[0]) begin
        if (na == 8'h00) fa = pixel_num;
        la = pixel_num;
      end
      if (vertical_out[12] != pv[12] && nb == 8'h00) fb = pixel_num;
      na += 8'(vertical_out[0] != pv[0]);
      nb += 8'(vertical_out[12] != pv[12]);
      nh += 8'(horizontal_blanking != ph);
      pv = vertical_out;
      ph = horizontal_blanking;
    end
    @(posedge ref_clk);
    #1;
  endtask

  task automatic alt_test;
    logic [11:0] r [4];
    r = '{grp_a_repeats_first, grp_a_repeats_second, grp_a_repeats_third, grp_a_repeats_fourth};
    for (int m = 0; m < 4; m++) begin
      grp_a_alt_select = 2'(m);
      blank_alternation_on = m[0];
      start();
      for (int k = 0; k < 4; k++) begin
        check(line_odd, 16'(k % 2 == 0));
        run_line();
        check(na, r[k % (m + 1)]);
        check(nb, (k % 2 == 0) ? grp_b_repeats_odd : grp_b_repeats_even);
        check(nh, m[0] ? ((k % 2 == 0) ? 16'h0002 : 16'h0004) : 16'h0006);
      end
    end
    $display("alternation test done");
  endtask

  task automatic group_test;
    grp_a_alt_select = 2'h0;
    combine_groups = 1'b1;
    start();
    run_line();
    check(na, 16'h0002);
    check(nb, 16'h0002);
    combine_groups = 1'b0;
    output_group_map = 13'h0000;
    start();
    run_line();
    check(nb, 16'h0001);
    output_group_map = 13'h1000;
    $display("group test done");
  endtask

  task automatic mask_test;
    grp_a_repeats_first = 12'h004;
    for (int m = 0; m < 5; m++) begin
      output_mask_mode = (m == 4) ? 2'h1 : 2'(m);
      hold_on = (m == 4);
      start();
      run_line();
      check(na, 16'(4 - m[0] - m[1]));
      // Start pixel, one cycle to activate, toggle at pos 3, one edge out
      if (m == 0) begin
        check(fa, 16'h0007);
        check(la, 16'h0013);
        check(fb, 16'h0017);
      end
    end
    {output_mask_mode, hold_on} = 3'h0;
    grp_a_repeats_first = 12'h001;
    $display("mask test done");
  endtask

  task automatic insert_test;
    {grp_b_repeats_odd, grp_b_repeats_even} = {12'h002, 12'h002};
    special_insert_on = 1'b1;
    start();
    for (int k = 0; k < 3; k++) begin
      run_line();
      check(na, (k == 1) ? 16'h0003 : 16'h0001);
    end
    special_insert_on = 1'b0;
    $display("insertion test done");
  endtask

  initial begin
    {rst, seq_run} = 2'h3;
    {seq_start, hold_on, special_insert_on, combine_groups, blank_alternation_on} = 5'h00;
    {grp_a_alt_select, output_mask_mode} = 4'h0;
    {grp_a_pattern_select, grp_b_pattern_select} = 10'h061;
    {line_len, grp_a_begin_pixel, grp_a_pattern_len} = {13'h0028, 13'h0002, 13'h0004};
    {grp_b_begin_pixel, grp_b_pattern_len} = {13'h0014, 13'h0003};
    {grp_b_repeats_odd, grp_b_repeats_even, special_insert_line} = {12'h003, 12'h001, 12'h001};
    {grp_a_repeats_first, grp_a_repeats_second} = {12'h001, 12'h002};
    {grp_a_repeats_third, grp_a_repeats_fourth} = {12'h003, 12'h004};
    {mask_begin_one, mask_end_one, mask_begin_two} = {13'h0006, 13'h0009, 13'h000D};
    {mask_end_two, output_group_map, start_polarity} = {13'h0010, 13'h1000, 13'h0AAA};
    {blank_edge_pos_1, blank_edge_pos_2, blank_edge_pos_3} = {13'h0005, 13'h000A, 13'h000F};
    {blank_edge_pos_4, blank_edge_pos_5, blank_edge_pos_6} = {13'h0014, 13'h0019, 13'h001E};
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    alt_test();
    group_test();
    mask_test();
    insert_test();
    end_sim();
  end
endmodule // ccd_vertical_sequence_gen_tb_top

bind cvs_vseq_gen cvs_vseq_sva chk (.*);
